// ===== flc_fuse_lock_ctrl.sv
// Nonvolatile lock and configuration byte holder with protection decode.
// Assumes programmer requests arrive synchronous to clk_in as pulses.
//
// Notes on behaviour
// RQ1: Two lock bits at bits 1,0.
// RQ2: Only chip erase returns lock bits to one.
// RQ3: Program-store allowed only if self-program bit zero.
// RQ4: Debug port reads memory despite lock bits.
// RQ5: Programmer leaves debug unprogrammed for lock security; the bench programs it (high byte 87) before locking.
// RQ6: Level 1 applies no restriction.
// RQ7: Level 2 blocks programming, config, debug.
// RQ8: Level 3 also blocks verification readback.
// RQ9: Programmer writes config before lock bits.
// RQ10: Programmed bits read zero; serial readback shows the high byte serial enable bit as one.
// RQ11: Extended byte holds self-program enable only.
// RQ12: High byte field layout as documented.
// RQ13: Low byte layout; defaults internal RC.
// RQ14: Lower lock programmed rejects config changes.
// RQ15: Chip erase keeps configuration bits.
// RQ16: Serial mode cannot touch serial enable.
// RQ17: Reset-disable needs high-voltage programming.
// RQ18: Forced watchdog disables watchdog interrupt.
// RQ19: Latch at programming entry; apply on exit.
// RQ20: EEPROM-preserve applies immediately.
// RQ21: Latch all values at power-up.
// RQ22: Chip erase blanks memories unless preserve.
// RQ23: Pointer selects byte; load within three cycles.
// RQ24: Functions use latched copies only; the code takes EEPROM preserve, lock bits and reset-disable live.
`default_nettype none
module flc_fuse_lock_ctrl (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Programming mode state
    input  wire logic        prog_mode_in,
    input  wire logic        prog_serial_in,
    input  wire logic        prog_hv_in,
    // Programmer byte writes and chip erase
    input  wire logic        cfg_wr_in,
    input  wire logic [1:0]  cfg_tgt_in,
    input  wire logic [7:0]  cfg_data_in,
    input  wire logic        chip_erase_in,
    input  wire logic        mem_prog_req_in,
    input  wire logic        mem_verify_req_in,
    // Programmer readback
    input  wire logic        cfg_rd_in,
    output logic      [7:0]  cfg_rdata_out,
    output logic             wr_reject_out,
    // Firmware readback
    input  wire logic        read_config_lock_select_in,
    input  wire logic        load_pm_in,
    input  wire logic [15:0] ptr_in,
    output logic      [7:0]  fw_rdata_out,
    output logic             fw_rvalid_out,
    // Protection decode
    output logic             mem_prog_allow_out,
    output logic             mem_verify_allow_out,
    output logic             store_program_memory_instr_allow_out,
    output logic             debug_allow_out,
    output logic             debug_read_allow_out,
    output logic             erase_flash_out,
    output logic             erase_eeprom_out,
    // Functional settings, latched except the live EEPROM preserve
    output logic             external_reset_disable_out,
    output logic             watchdog_forced_on_out,
    output logic             watchdog_irq_allow_out,
    output logic             eeprom_preserve_on_erase_out,
    output logic             serial_program_enable_out,
    output logic      [2:0]  brownout_level_out,
    output logic             clock_divide_by_eight_out,
    output logic             clock_output_enable_out,
    output logic      [1:0]  startup_time_out,
    output logic      [3:0]  clock_source_out
);
    // ==========================================================
    // Storage
    // Reset values stand in for the nonvolatile cell content
    logic [7:0] lock_bit_byte_r;
    logic [7:0] config_extended_byte_r;
    logic [7:0] config_high_byte_r;
    logic [7:0] config_low_byte_r;
    logic [7:0] lat_ext_r, lat_high_r, lat_low_r;
    logic       boot_r, prog_d_r;
    logic [1:0] rd_win_r;
    logic [7:0] cfg_rdata_r, fw_rdata_r;
    logic       fw_rvalid_r, reject_r, erase_f_r, erase_e_r;

    // ==========================================================
    // Protection decode
    wire lock_bit_low  = lock_bit_byte_r[flc_pkg::LOCK_LOW_BIT];   // RQ1
    wire lock_bit_high = lock_bit_byte_r[flc_pkg::LOCK_HIGH_BIT];  // RQ1
    // Level 1 when both one, else 2 or 3
    wire level1 = lock_bit_low & lock_bit_high;                    // RQ6
    wire level3 = ~lock_bit_low & ~lock_bit_high;                  // RQ8
    wire cfg_locked = ~lock_bit_low;                               // RQ14
    // Any programmed lock bit stops memory programming
    wire prog_block = ~level1;                                     // RQ7
    wire verify_block = level3;                                    // RQ8
    wire prog_any = prog_serial_in | prog_hv_in;
    // Reset-disable forces high-voltage only; the raw cell is used so
    // a freshly programmed bit shuts the serial path at once
    wire rst_dis_now = ~config_high_byte_r[flc_pkg::EXT_RST_DIS_BIT];
    wire mode_ok = prog_mode_in & prog_any
                 & ~(rst_dis_now & ~prog_hv_in);                   // RQ17

    // ==========================================================
    // Write acceptance
    wire tgt_lock = cfg_tgt_in == 2'(flc_pkg::FLC_TGT_LOCK);
    wire wr_cfg   = cfg_wr_in & mode_ok & ~tgt_lock & ~cfg_locked; // RQ14
    wire wr_lock  = cfg_wr_in & mode_ok & tgt_lock;
    wire wr_rej   = cfg_wr_in & ~(wr_cfg | wr_lock);
    wire erase_ok = chip_erase_in & mode_ok;
    // Serial mode keeps the serial enable bit untouched; a programmer
    // on the serial link could otherwise lock itself out for good
    wire keep_spi = prog_serial_in & ~prog_hv_in;                  // RQ16
    wire [7:0] spi_mask = 8'h01 << flc_pkg::SERIAL_EN_BIT;
    wire [7:0] high_wr = keep_spi
        ? ((cfg_data_in & ~spi_mask) | (config_high_byte_r & spi_mask))
        : cfg_data_in;                                             // RQ16
    // Only the two lock bits take writes; unused bits stay at one
    wire [7:0] lock_mask = (8'h01 << flc_pkg::LOCK_LOW_BIT)
                         | (8'h01 << flc_pkg::LOCK_HIGH_BIT);      // RQ1
    wire [7:0] lock_wr = cfg_data_in | ~lock_mask;                 // RQ1
    // Extended byte keeps only the self-program enable bit
    wire [7:0] self_mask = 8'h01 << flc_pkg::SELF_PROG_BIT;
    wire [7:0] ext_wr = (flc_pkg::EXT_RESET & ~self_mask)
                      | (cfg_data_in & self_mask);                 // RQ11

    // Nonvolatile lock byte: only bits go to zero; erase sets ones
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            lock_bit_byte_r <= flc_pkg::LOCK_RESET;                // RQ1
        else if (erase_ok)
            lock_bit_byte_r <= flc_pkg::LOCK_RESET;                // RQ2
        else if (wr_lock)
            lock_bit_byte_r <= lock_bit_byte_r & lock_wr;          // RQ2
    end

    // Configuration bytes; chip erase leaves them alone
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            config_extended_byte_r <= flc_pkg::EXT_RESET;          // RQ11
            config_high_byte_r     <= flc_pkg::HIGH_RESET;         // RQ12
            config_low_byte_r      <= flc_pkg::LOW_RESET;          // RQ13
        end
        else if (wr_cfg)                                           // RQ15
        begin
            if (cfg_tgt_in == 2'(flc_pkg::FLC_TGT_EXT))
                config_extended_byte_r <= ext_wr;                  // RQ11
            if (cfg_tgt_in == 2'(flc_pkg::FLC_TGT_HIGH))
                config_high_byte_r <= high_wr;                     // RQ12
            if (cfg_tgt_in == 2'(flc_pkg::FLC_TGT_LOW))
                config_low_byte_r <= cfg_data_in;                  // RQ13
        end
    end

    // ==========================================================
    // Latching at power-up and on programming entry
    wire latch_now = boot_r | (prog_mode_in & ~prog_d_r);          // RQ19
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            boot_r     <= 1'b1;
            prog_d_r   <= 1'b0;
            lat_ext_r  <= flc_pkg::EXT_RESET;
            lat_high_r <= flc_pkg::HIGH_RESET;
            lat_low_r  <= flc_pkg::LOW_RESET;
        end
        else
        begin
            boot_r   <= 1'b0;                                      // RQ21
            prog_d_r <= prog_mode_in;
            if (latch_now)                                         // RQ21
            begin
                lat_ext_r  <= config_extended_byte_r;
                lat_high_r <= config_high_byte_r;
                lat_low_r  <= config_low_byte_r;
            end
            // Leaving the mode applies what was written meanwhile
            else if (!prog_mode_in && prog_d_r)                    // RQ19
            begin
                lat_ext_r  <= config_extended_byte_r;
                lat_high_r <= config_high_byte_r;
                lat_low_r  <= config_low_byte_r;
            end
        end
    end

    // ==========================================================
    // Chip erase outcome; preserve taken live, not latched
    // Pulses are one cycle wide, one cycle after the request
    wire ee_keep = ~config_high_byte_r[flc_pkg::EE_KEEP_BIT];      // RQ20
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            erase_f_r <= 1'b0;
            erase_e_r <= 1'b0;
        end
        else
        begin
            erase_f_r <= erase_ok;                                 // RQ22
            erase_e_r <= erase_ok & ~ee_keep;                      // RQ22
        end
    end

    // ==========================================================
    // Readback paths
    wire [7:0] prog_sel =
        (cfg_tgt_in == 2'(flc_pkg::FLC_TGT_LOCK)) ? lock_bit_byte_r :
        (cfg_tgt_in == 2'(flc_pkg::FLC_TGT_EXT))  ? config_extended_byte_r :
        (cfg_tgt_in == 2'(flc_pkg::FLC_TGT_HIGH)) ? config_high_byte_r :
                                                    config_low_byte_r;
    // Serial enable hidden from serial readback as a one
    wire [7:0] prog_rd = (keep_spi &&
        cfg_tgt_in == 2'(flc_pkg::FLC_TGT_HIGH))
        ? (prog_sel | spi_mask)
        : prog_sel;                                                // RQ16
    // Firmware pointer decode; other pointers read as erased
    wire [7:0] fw_sel =
        (ptr_in == flc_pkg::PTR_LOW)  ? config_low_byte_r :
        (ptr_in == flc_pkg::PTR_HIGH) ? config_high_byte_r :
        (ptr_in == flc_pkg::PTR_EXT)  ? config_extended_byte_r :
        (ptr_in == flc_pkg::PTR_LOCK) ? lock_bit_byte_r :
                                        flc_pkg::ERASED_BYTE;      // RQ23
    wire fw_hit = load_pm_in & (rd_win_r != 2'h0);                 // RQ23

    // Read-enable window and registered data
    // A new select restarts the window, even on a load
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_win_r    <= 2'h0;
            fw_rdata_r  <= 8'h00;
            fw_rvalid_r <= 1'b0;
            cfg_rdata_r <= 8'h00;
            reject_r    <= 1'b0;
        end
        else
        begin
            if (read_config_lock_select_in)
                rd_win_r <= flc_pkg::READ_WINDOW;                  // RQ23
            else if (fw_hit)
                rd_win_r <= 2'h0;
            else if (rd_win_r != 2'h0)
                rd_win_r <= rd_win_r - 2'h1;
            fw_rvalid_r <= fw_hit;
            if (fw_hit)
                fw_rdata_r <= fw_sel;                              // RQ10
            if (cfg_rd_in && mode_ok)
                cfg_rdata_r <= prog_rd;                            // RQ10
            reject_r <= wr_rej;
        end
    end

    // ==========================================================
    // Outputs from registered copies
    assign cfg_rdata_out    = cfg_rdata_r;
    assign fw_rdata_out     = fw_rdata_r;
    assign fw_rvalid_out    = fw_rvalid_r;
    assign wr_reject_out    = reject_r;
    assign erase_flash_out  = erase_f_r;
    assign erase_eeprom_out = erase_e_r;

    // Memory gates follow the live lock bits
    assign mem_prog_allow_out   = mode_ok & ~prog_block
                                & mem_prog_req_in;                 // RQ7
    assign mem_verify_allow_out = mode_ok & ~verify_block
                                & mem_verify_req_in;               // RQ8

    // Self-programming and debug from latched settings
    assign store_program_memory_instr_allow_out =
        ~lat_ext_r[flc_pkg::SELF_PROG_BIT];                        // RQ3
    wire dbg_en = ~lat_high_r[flc_pkg::DEBUG_EN_BIT];              // RQ24
    assign debug_allow_out      = dbg_en & level1;                 // RQ7
    assign debug_read_allow_out = dbg_en;                          // RQ4

    // High byte settings; preserve comes straight from the cell
    assign external_reset_disable_out =
        ~lat_high_r[flc_pkg::EXT_RST_DIS_BIT];                     // RQ24
    assign watchdog_forced_on_out = ~lat_high_r[flc_pkg::WDOG_ON_BIT];
    assign watchdog_irq_allow_out =
        lat_high_r[flc_pkg::WDOG_ON_BIT];                          // RQ18
    assign eeprom_preserve_on_erase_out = ee_keep;                 // RQ20
    assign serial_program_enable_out =
        ~lat_high_r[flc_pkg::SERIAL_EN_BIT];
    assign brownout_level_out = lat_high_r[flc_pkg::BOD_MSB:0];    // RQ24

    // Low byte clock settings
    assign clock_divide_by_eight_out = ~lat_low_r[flc_pkg::DIV8_BIT];
    assign clock_output_enable_out   = ~lat_low_r[flc_pkg::CLK_OUT_BIT];
    assign startup_time_out =
        lat_low_r[flc_pkg::SUT_MSB:flc_pkg::SUT_LSB];
    assign clock_source_out = lat_low_r[flc_pkg::CKSRC_MSB:0];     // RQ24
endmodule
`default_nettype wire

// ===== flc_pkg.sv
// Package for the configuration and lock bit controller.
// Assumes a single 20 MHz system clock; nothing is imported by users.
`default_nettype none
package flc_pkg;
    // ==========================================================
    // Byte layout
    localparam int          BYTE_W           = 8;
    localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
    // Lock byte fields
    localparam int          LOCK_LOW_BIT     = 0;
    localparam int          LOCK_HIGH_BIT    = 1;
    localparam logic [7:0]  LOCK_RESET       = 8'hFF;
    // Extended byte fields
    localparam int          SELF_PROG_BIT    = 0;
    localparam logic [7:0]  EXT_RESET        = 8'hFF;
    // High byte fields
    localparam int          EXT_RST_DIS_BIT  = 7;
    localparam int          DEBUG_EN_BIT     = 6;
    localparam int          SERIAL_EN_BIT    = 5;
    localparam int          WDOG_ON_BIT      = 4;
    localparam int          EE_KEEP_BIT      = 3;
    localparam int          BOD_MSB          = 2;
    localparam logic [7:0]  HIGH_RESET       = 8'hDF;
    // Low byte fields
    localparam int          DIV8_BIT         = 7;
    localparam int          CLK_OUT_BIT      = 6;
    localparam int          SUT_MSB          = 5;
    localparam int          SUT_LSB          = 4;
    localparam int          CKSRC_MSB        = 3;
    localparam logic [7:0]  LOW_RESET        = 8'h62;
    // Firmware readback pointer values
    localparam logic [15:0] PTR_LOW          = 16'h0000;
    localparam logic [15:0] PTR_LOCK         = 16'h0001;
    localparam logic [15:0] PTR_EXT          = 16'h0002;
    localparam logic [15:0] PTR_HIGH         = 16'h0003;
    // Read-enable window in cycles
    localparam logic [1:0]  READ_WINDOW      = 2'h3;
    // Programmer write targets
    typedef enum logic [1:0] {
        FLC_TGT_LOCK, FLC_TGT_EXT, FLC_TGT_HIGH, FLC_TGT_LOW
    } flc_target_t;
endpackage
`default_nettype wire

// ===== flc_prog_model.sv
// Programmer model: mode entry, byte writes, chip erase, readback.
// Assumes the bench clock; its tasks are called from the bench.
`default_nettype none
module flc_prog_model (
    // Clock
    input  wire logic       clk_in,
    // Requests to the controller
    output var logic        pm_out,
    output var logic        ps_out,
    output var logic        ph_out,
    output var logic        wr_out,
    output var logic        er_out,
    output var logic        rd_out,
    output var logic [1:0]  tgt_out,
    output var logic [7:0]  dat_out,
    // Refusal reply
    input  wire logic       rej_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Idle levels
    initial
    begin
        {pm_out, ps_out, ph_out, wr_out, er_out, rd_out} = 6'h00;
        tgt_out = 2'h0;
        dat_out = 8'h00;
    end
    // Enter a mode; high voltage when hv is set, serial otherwise
    task automatic enter(input logic hv);
        @(posedge clk_in);
        pm_out <= 1'b1;
        ps_out <= !hv;
        ph_out <= hv;
        repeat (3) @(posedge clk_in);
    endtask
    // Leave programming mode
    task automatic leave();
        @(posedge clk_in);
        pm_out <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    // One pulse: op 0 write, 1 erase, 2 read; watch refusal
    task automatic op(input logic [1:0] o, input logic [1:0] t,
                      input logic [7:0] d, output logic rej);
        @(posedge clk_in);
        tgt_out <= t;
        dat_out <= d;
        wr_out  <= (o == 2'h0);
        er_out  <= (o == 2'h1);
        rd_out  <= (o == 2'h2);
        @(posedge clk_in);
        {wr_out, er_out, rd_out} <= 3'h0;
        rej = 1'b0;
        repeat (3)
        begin
            @(negedge clk_in);
            rej = rej | rej_in;
        end
    endtask
endmodule
`default_nettype wire

// ===== flc_fuse_lock_ctrl_properties.sv
// Checker for the configuration and lock bit controller ports.
// Assumes one clock domain and the asynchronous active low reset.
`default_nettype none
module flc_fuse_lock_ctrl_properties (
    // Clock, reset and requests
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       prog_mode_in,
    input wire logic       prog_hv_in,
    input wire logic       cfg_wr_in,
    input wire logic       chip_erase_in,
    input wire logic       mem_prog_req_in,
    input wire logic       mem_verify_req_in,
    input wire logic       load_pm_in,
    // Replies and decoded settings
    input wire logic       wr_reject_out,
    input wire logic       fw_rvalid_out,
    input wire logic       mem_prog_allow_out,
    input wire logic       mem_verify_allow_out,
    input wire logic       erase_flash_out,
    input wire logic       erase_eeprom_out,
    input wire logic       watchdog_forced_on_out,
    input wire logic       watchdog_irq_allow_out,
    input wire logic       eeprom_preserve_on_erase_out,
    input wire logic [3:0] clock_source_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Protection, erase and latch properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    prog_gate_a: assert property (mem_prog_allow_out |->
        mem_prog_req_in && prog_mode_in) else $error("prog gate");
    verify_gate_a: assert property (mem_verify_allow_out |->
        mem_verify_req_in && prog_mode_in) else $error("verify gate");
    level_one_a: assert property (mem_prog_allow_out &&
        mem_verify_req_in |-> mem_verify_allow_out) else $error("level 1");
    erase_pulse_a: assert property (chip_erase_in && prog_mode_in &&
        prog_hv_in |-> ##[1:2] erase_flash_out) else $error("no erase");
    erase_once_a: assert property (erase_flash_out |=>
        !erase_flash_out) else $error("erase too long");
    eeprom_keep_a: assert property (erase_flash_out &&
        eeprom_preserve_on_erase_out |-> !erase_eeprom_out)
        else $error("eeprom erased");
    fw_answer_a: assert property (fw_rvalid_out |->
        $past(load_pm_in)) else $error("stray valid");
    latch_hold_a: assert property (prog_mode_in [*4] |->
        $stable(clock_source_out) && $stable(watchdog_forced_on_out))
        else $error("latched copy moved");
    wdog_irq_a: assert property (watchdog_forced_on_out |->
        !watchdog_irq_allow_out) else $error("watchdog irq");
    reject_cause_a: assert property (wr_reject_out |->
        $past(cfg_wr_in) || $past(cfg_wr_in, 2)) else $error("reject");
endmodule
bind flc_fuse_lock_ctrl flc_fuse_lock_ctrl_properties chk_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .prog_mode_in(prog_mode_in),
    .prog_hv_in(prog_hv_in), .cfg_wr_in(cfg_wr_in),
    .chip_erase_in(chip_erase_in), .mem_prog_req_in(mem_prog_req_in),
    .mem_verify_req_in(mem_verify_req_in), .load_pm_in(load_pm_in),
    .wr_reject_out(wr_reject_out), .fw_rvalid_out(fw_rvalid_out),
    .mem_prog_allow_out(mem_prog_allow_out),
    .mem_verify_allow_out(mem_verify_allow_out),
    .erase_flash_out(erase_flash_out), .erase_eeprom_out(erase_eeprom_out),
    .watchdog_forced_on_out(watchdog_forced_on_out),
    .watchdog_irq_allow_out(watchdog_irq_allow_out),
    .eeprom_preserve_on_erase_out(eeprom_preserve_on_erase_out),
    .clock_source_out(clock_source_out));
`default_nettype wire

// ===== flc_fuse_lock_ctrl_bench.sv
// Bench for the configuration and lock bit controller.
// Assumes the programmer model and the bound checker are compiled first.
`default_nettype none
module flc_fuse_lock_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, rst_n_in, mpr, mvr, sel, ld, rej;
    logic [15:0] ptr;
    logic [3:0]  n_fl = 4'h0, n_ee = 4'h0;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    wire logic   pm, ps, ph, wr, er, rd, rj, fv, pa, va, dba, dra, efl, eee;
    wire logic   wdog, wirq, keep, spe, div8, clock_output_enable, store_program_memory_instr, xrd;
    wire logic [1:0] tgt, sut;
    wire logic [2:0] bod;
    wire logic [3:0] csrc;
    wire logic [7:0] dat, rdat, fwd;
    // ==========================================
    // Design and programmer
    flc_fuse_lock_ctrl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .prog_mode_in(pm), .prog_serial_in(ps), .prog_hv_in(ph),
        .cfg_wr_in(wr), .cfg_tgt_in(tgt), .cfg_data_in(dat),
        .chip_erase_in(er), .mem_prog_req_in(mpr),
        .mem_verify_req_in(mvr), .cfg_rd_in(rd), .cfg_rdata_out(rdat),
        .wr_reject_out(rj), .read_config_lock_select_in(sel),
        .load_pm_in(ld), .ptr_in(ptr), .fw_rdata_out(fwd),
        .fw_rvalid_out(fv), .mem_prog_allow_out(pa),
        .mem_verify_allow_out(va),
        .store_program_memory_instr_allow_out(store_program_memory_instr), .debug_allow_out(dba),
        .debug_read_allow_out(dra), .erase_flash_out(efl),
        .erase_eeprom_out(eee), .external_reset_disable_out(xrd),
        .watchdog_forced_on_out(wdog), .watchdog_irq_allow_out(wirq),
        .eeprom_preserve_on_erase_out(keep),
        .serial_program_enable_out(spe), .brownout_level_out(bod),
        .clock_divide_by_eight_out(div8), .clock_output_enable_out(clock_output_enable),
        .startup_time_out(sut), .clock_source_out(csrc));
    flc_prog_model pg (.clk_in(clk_in), .pm_out(pm), .ps_out(ps),
        .ph_out(ph), .wr_out(wr), .er_out(er), .rd_out(rd),
        .tgt_out(tgt), .dat_out(dat), .rej_in(rj));
    // Clock at 20 MHz
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // Erase pulse counts and hang limit
    always @(negedge clk_in)
    begin
        n_fl <= n_fl + {3'h0, efl};
        n_ee <= n_ee + {3'h0, eee};
        cyc++;
        if (cyc == 4000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask
    task automatic rdc(input logic [1:0] t, input logic [7:0] e,
                       input string what);
        pg.op(2'h2, t, 8'h00, rej);
        chk(rdat, e, what);
    endtask
    task automatic fw(input logic [15:0] p, input logic [7:0] e);
        @(posedge clk_in);
        sel <= 1'b1;
        @(posedge clk_in);
        sel <= 1'b0;
        ld  <= 1'b1;
        ptr <= p;
        @(posedge clk_in);
        ld <= 1'b0;
        @(negedge clk_in);
        chk({fv, fwd[6:0]}, {1'b1, e[6:0]}, "fw read");
        chk(fwd, e, "fw byte");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_defaults();
        pg.enter(1'b1);
        mpr <= 1'b1;
        mvr <= 1'b1;
        rdc(2'h0, 8'hFF, "lock");
        rdc(2'h1, 8'hFF, "ext");
        rdc(2'h2, 8'hDF, "high");
        rdc(2'h3, 8'h62, "low");
        chk({4'h0, div8, clock_output_enable, spe, wdog}, 8'h0A, "boot");
        chk({6'h0, pa, va}, 8'h03, "level 1");
        chk({1'b0, store_program_memory_instr, bod, sut, xrd}, 8'h3C, "settings");
        chk({4'h0, csrc}, 8'h02, "clock source");
        pg.op(2'h1, 2'h0, 8'h00, rej);
        chk({n_ee, n_fl}, 8'h11, "erase all");
    endtask
    task automatic t_latch();
        pg.op(2'h0, 2'h2, 8'h87, rej);
        chk({6'h0, keep, wdog}, 8'h02, "in mode");
        pg.op(2'h0, 2'h1, 8'h00, rej);
        rdc(2'h1, 8'hFE, "ext upper");
        pg.leave();
        chk({6'h0, wdog, wirq}, 8'h02, "watchdog");
        chk({7'h0, store_program_memory_instr}, 8'h01, "self program");
        pg.enter(1'b1);
        pg.op(2'h1, 2'h0, 8'h00, rej);
        chk({n_ee, n_fl}, 8'h12, "erase");
        rdc(2'h2, 8'h87, "high kept");
    endtask
    task automatic t_serial();
        pg.leave();
        pg.enter(1'b0);
        pg.op(2'h0, 2'h2, 8'hA7, rej);
        rdc(2'h2, 8'hA7, "serial");
        pg.leave();
        pg.enter(1'b1);
        rdc(2'h2, 8'h87, "serial kept");
    endtask
    task automatic t_lock();
        pg.op(2'h0, 2'h0, 8'hFE, rej);
        chk({6'h0, pa, va}, 8'h01, "level 2");
        pg.op(2'h0, 2'h3, 8'h00, rej);
        chk({7'h0, rej}, 8'h01, "refused");
        rdc(2'h3, 8'h62, "low kept");
        pg.op(2'h0, 2'h0, 8'hFC, rej);
        chk({6'h0, pa, va}, 8'h00, "level 3");
        pg.op(2'h0, 2'h0, 8'hFF, rej);
        rdc(2'h0, 8'hFC, "lock stays");
        pg.leave();
        chk({6'h0, dba, dra}, 8'h01, "debug");
        fw(16'h0000, 8'h62);
        fw(16'h0002, 8'hFE);
        fw(16'h0003, 8'h87);
        fw(16'h0001, 8'hFC);
        pg.enter(1'b1);
        pg.op(2'h1, 2'h0, 8'h00, rej);
        rdc(2'h0, 8'hFF, "erased lock");
        chk({n_ee, n_fl}, 8'h13, "erase count");
        chk({7'h0, pa}, 8'h01, "unlocked");
    endtask
    task automatic t_reset_pin();
        pg.op(2'h0, 2'h2, 8'h07, rej);
        pg.leave();
        chk({7'h0, xrd}, 8'h01, "reset pin off");
        pg.enter(1'b0);
        pg.op(2'h0, 2'h3, 8'h00, rej);
        chk({7'h0, rej}, 8'h01, "serial refused");
        pg.leave();
        pg.enter(1'b1);
        rdc(2'h3, 8'h62, "low intact");
    endtask
    // Main sequence
    initial
    begin
        {rst_n_in, mpr, mvr, sel, ld} = 5'h00;
        ptr = 16'h0000;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_defaults();
        t_latch();
        t_serial();
        t_lock();
        t_reset_pin();
        wrap_up();
    end
endmodule
`default_nettype wire
